// File: inc/iao_pkg.sv
// shared constants and types for the integer alu datapath
package iao_pkg;
   typedef enum logic [4:0] {
      OP_DIV_U    = 5'h00, OP_DIV_S    = 5'h01, OP_COMPARE  = 5'h02,
      OP_NEGATE   = 5'h03, OP_EXT_SIGN = 5'h04, OP_EXT_ZERO = 5'h05,
      OP_LOG_AND  = 5'h06, OP_LOG_OR   = 5'h07, OP_LOG_XOR  = 5'h08,
      OP_LOG_INV  = 5'h09, OP_SHA_L    = 5'h0a, OP_SHA_R    = 5'h0b,
      OP_SHL_L    = 5'h0c, OP_SHL_R    = 5'h0d, OP_ROT_L    = 5'h0e,
      OP_ROT_R    = 5'h0f, OP_ROTC_L   = 5'h10, OP_ROTC_R   = 5'h11,
      OP_BIT_SET  = 5'h12, OP_BIT_CLR  = 5'h13, OP_BIT_INV  = 5'h14,
      OP_BIT_TEST = 5'h15, OP_C_AND    = 5'h16, OP_C_ANDN   = 5'h17
   } iao_op_t;
   typedef enum logic [1:0] {
      SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2
   } iao_size_t;
   localparam int          NUM_REGS  = 8;
   localparam logic [31:0] MSB_B     = 32'h0000_0080;
   localparam logic [31:0] MSB_W     = 32'h0000_8000;
   localparam logic [31:0] MSB_L     = 32'h8000_0000;
   localparam logic [31:0] MASK_B    = 32'h0000_00ff;
   localparam logic [31:0] MASK_W    = 32'h0000_ffff;
   localparam logic [31:0] MASK_L    = 32'hffff_ffff;
   localparam logic [31:0] REG_RST   = 32'h0000_0000;
   localparam logic [3:0]  FLAGS_RST = 4'h0;
   // flag positions inside the condition flags register
   localparam int          FLG_N     = 3;
   localparam int          FLG_Z     = 2;
   localparam int          FLG_V     = 1;
   localparam int          FLG_C     = 0;
endpackage : iao_pkg

// File: src/iao_alu.sv
// integer alu datapath with general register file and condition flags
`timescale 1ns/1ps
`default_nettype none
module iao_alu (
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              opValid,
   input  wire iao_pkg::iao_op_t  opCode,
   input  wire iao_pkg::iao_size_t opSize,
   input  wire logic [3:0]        dstSel,
   input  wire logic [3:0]        srcSel,
   input  wire logic              useImm,
   input  wire logic [31:0]       immData,
   input  wire logic [2:0]        bitImm,
   input  wire logic              bitFromReg,
   input  wire logic              useMem,
   input  wire logic [7:0]        memRdData,
   input  wire logic              loadEn,
   input  wire logic [2:0]        loadIdx,
   input  wire logic [31:0]       loadData,
   input  wire logic              flagLoadEn,
   input  wire logic [3:0]        flagLoadData,
   input  wire logic [2:0]        peekIdx,
   output logic [31:0]            resultOut,
   output logic [3:0]             flagsOut,
   output logic                   doneOut,
   output logic                   errOut,
   output logic                   memWrEn,
   output logic [7:0]             memWrData,
   output logic [31:0]            peekData
);
   logic [31:0]       regs [iao_pkg::NUM_REGS];
   logic [31:0]       dReg, sReg, dVal, sVal, msk, msb, dvd, diff, negR;
   logic [31:0]       res, uq, ur, sdvd, ssor, sq, sr, selByte;
   logic [7:0]        byteOp, newByte;
   logic [2:0]        bitPos;
   logic              bitSel, top, lo, legal, wrReg, memWr, taken;
   logic [3:0]        nf;
   iao_pkg::iao_size_t wsz;

   // part of a register seen at a size: sel[3] picks low byte / upper word
   function automatic logic [31:0] rdOp(input iao_pkg::iao_size_t sz,
                                        input logic [3:0] sel,
                                        input logic [31:0] r);
      if (sz == iao_pkg::SZ_B) begin
         rdOp = sel[3] ? {24'h000000, r[7:0]} : {24'h000000, r[15:8]};
      end else if (sz == iao_pkg::SZ_W) begin
         rdOp = sel[3] ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
      end else begin
         rdOp = r;
      end
   endfunction : rdOp

   // merge a sized value back into the full register, other parts kept
   function automatic logic [31:0] wrOp(input iao_pkg::iao_size_t sz,
                                        input logic [3:0] sel,
                                        input logic [31:0] old,
                                        input logic [31:0] v);
      wrOp = old;
      if (sz == iao_pkg::SZ_B) begin
         if (sel[3]) wrOp[7:0] = v[7:0];
         else wrOp[15:8] = v[7:0];
      end else if (sz == iao_pkg::SZ_W) begin
         if (sel[3]) wrOp[31:16] = v[15:0];
         else wrOp[15:0] = v[15:0];
      end else begin
         wrOp = v;
      end
   endfunction : wrOp

   function automatic logic [31:0] maskOf(input iao_pkg::iao_size_t sz);
      if (sz == iao_pkg::SZ_B) maskOf = iao_pkg::MASK_B;
      else if (sz == iao_pkg::SZ_W) maskOf = iao_pkg::MASK_W;
      else maskOf = iao_pkg::MASK_L;
   endfunction : maskOf

   function automatic logic [31:0] msbOf(input iao_pkg::iao_size_t sz);
      if (sz == iao_pkg::SZ_B) msbOf = iao_pkg::MSB_B;
      else if (sz == iao_pkg::SZ_W) msbOf = iao_pkg::MSB_W;
      else msbOf = iao_pkg::MSB_L;
   endfunction : msbOf

   // allowed operand sizes per operation
   function automatic logic sizeOk(input iao_pkg::iao_op_t op,
                                   input iao_pkg::iao_size_t sz);
      case (op)
         iao_pkg::OP_DIV_U, iao_pkg::OP_DIV_S:
            sizeOk = (sz == iao_pkg::SZ_B) || (sz == iao_pkg::SZ_W);
         iao_pkg::OP_EXT_SIGN, iao_pkg::OP_EXT_ZERO:
            sizeOk = (sz == iao_pkg::SZ_W) || (sz == iao_pkg::SZ_L);
         iao_pkg::OP_BIT_SET, iao_pkg::OP_BIT_CLR, iao_pkg::OP_BIT_INV,
         iao_pkg::OP_BIT_TEST, iao_pkg::OP_C_AND, iao_pkg::OP_C_ANDN:
            sizeOk = (sz == iao_pkg::SZ_B);
         default: sizeOk = (sz != 2'h3);
      endcase
   endfunction : sizeOk

   // operand fetch and every result, all in one cycle
   always_comb begin
      dReg    = regs[dstSel[2:0]];
      sReg    = regs[srcSel[2:0]];
      msk     = maskOf(opSize);
      msb     = msbOf(opSize);
      dVal    = rdOp(opSize, dstSel, dReg);
      sVal    = useImm ? (immData & msk) : rdOp(opSize, srcSel, sReg);
      selByte = rdOp(iao_pkg::SZ_B, srcSel, sReg);
      bitPos  = bitFromReg ? selByte[2:0] : bitImm;
      selByte = rdOp(iao_pkg::SZ_B, dstSel, dReg);
      byteOp  = useMem ? memRdData : selByte[7:0];
      bitSel  = byteOp[bitPos];
      diff    = (dVal - sVal) & msk;
      negR    = (32'h0000_0000 - dVal) & msk;
      top     = |(dVal & msb);
      lo      = dVal[0];
      // wider dividend: word register for byte form, longword for word
      dvd     = rdOp((opSize == iao_pkg::SZ_B) ? iao_pkg::SZ_W
                     : iao_pkg::SZ_L, dstSel, dReg);
      uq      = (sVal != 32'h0) ? dvd / sVal : 32'h0;
      ur      = (sVal != 32'h0) ? dvd % sVal : 32'h0;
      sdvd    = (opSize == iao_pkg::SZ_B) ? {{16{dvd[15]}}, dvd[15:0]} : dvd;
      ssor    = (opSize == iao_pkg::SZ_B) ? {{24{sVal[7]}}, sVal[7:0]}
                : {{16{sVal[15]}}, sVal[15:0]};
      sq      = (sVal != 32'h0) ? 32'($signed(sdvd) / $signed(ssor))
                : 32'h0;
      sr      = (sVal != 32'h0) ? 32'($signed(sdvd) % $signed(ssor))
                : 32'h0;
      legal   = sizeOk(opCode, opSize)
                && !(opCode == iao_pkg::OP_C_ANDN && bitFromReg);
      res     = dVal;
      newByte = byteOp;
      wrReg   = 1'b0;
      memWr   = 1'b0;
      wsz     = opSize;
      nf      = flagsOut;
      case (opCode)
         iao_pkg::OP_DIV_U, iao_pkg::OP_DIV_S: begin
            if (opCode == iao_pkg::OP_DIV_S) begin
               uq = sq;
               ur = sr;
            end
            // remainder high, quotient low; zero divisor leaves it alone
            wsz   = (opSize == iao_pkg::SZ_B) ? iao_pkg::SZ_W : iao_pkg::SZ_L;
            res   = (opSize == iao_pkg::SZ_B) ? {16'h0000, ur[7:0], uq[7:0]}
                    : {ur[15:0], uq[15:0]};
            wrReg = (sVal != 32'h0);
            nf[iao_pkg::FLG_N] = |(uq & msb);
            nf[iao_pkg::FLG_Z] = (sVal == 32'h0);
         end
         iao_pkg::OP_COMPARE, iao_pkg::OP_NEGATE: begin
            if (opCode == iao_pkg::OP_COMPARE) begin
               res = diff;
               nf[iao_pkg::FLG_C] = (dVal < sVal);
               nf[iao_pkg::FLG_V] = |((dVal ^ sVal) & (dVal ^ diff) & msb);
            end else begin
               res   = negR;
               wrReg = 1'b1;
               nf[iao_pkg::FLG_C] = (dVal != 32'h0);
               nf[iao_pkg::FLG_V] = |(dVal & negR & msb);
            end
            nf[iao_pkg::FLG_N] = |(res & msb);
            nf[iao_pkg::FLG_Z] = (res == 32'h0);
         end
         iao_pkg::OP_EXT_SIGN, iao_pkg::OP_EXT_ZERO, iao_pkg::OP_LOG_AND,
         iao_pkg::OP_LOG_OR, iao_pkg::OP_LOG_XOR, iao_pkg::OP_LOG_INV: begin
            case (opCode)
               iao_pkg::OP_EXT_SIGN:
                  res = (opSize == iao_pkg::SZ_W)
                        ? {16'h0000, {8{dVal[7]}}, dVal[7:0]}
                        : {{16{dVal[15]}}, dVal[15:0]};
               iao_pkg::OP_EXT_ZERO:
                  res = (opSize == iao_pkg::SZ_W)
                        ? {24'h000000, dVal[7:0]} : {16'h0000, dVal[15:0]};
               iao_pkg::OP_LOG_AND: res = dVal & sVal;
               iao_pkg::OP_LOG_OR:  res = dVal | sVal;
               iao_pkg::OP_LOG_XOR: res = dVal ^ sVal;
               default:             res = ~dVal & msk;
            endcase
            wrReg = 1'b1;
            nf[iao_pkg::FLG_N] = |(res & msb);
            nf[iao_pkg::FLG_Z] = (res == 32'h0);
            nf[iao_pkg::FLG_V] = 1'b0;
         end
         iao_pkg::OP_SHA_L, iao_pkg::OP_SHL_L, iao_pkg::OP_ROT_L,
         iao_pkg::OP_ROTC_L: begin
            res = (dVal << 1) & msk;
            if (opCode == iao_pkg::OP_ROT_L) res[0] = top;
            if (opCode == iao_pkg::OP_ROTC_L)
               res[0] = flagsOut[iao_pkg::FLG_C];
            wrReg = 1'b1;
            nf[iao_pkg::FLG_C] = top;
            nf[iao_pkg::FLG_N] = |(res & msb);
            nf[iao_pkg::FLG_Z] = (res == 32'h0);
            nf[iao_pkg::FLG_V] = 1'b0;
         end
         iao_pkg::OP_SHA_R, iao_pkg::OP_SHL_R, iao_pkg::OP_ROT_R,
         iao_pkg::OP_ROTC_R: begin
            res = dVal >> 1;
            if ((opCode == iao_pkg::OP_SHA_R && top)
                || (opCode == iao_pkg::OP_ROT_R && lo)
                || (opCode == iao_pkg::OP_ROTC_R
                    && flagsOut[iao_pkg::FLG_C]))
               res = res | msb;
            wrReg = 1'b1;
            nf[iao_pkg::FLG_C] = lo;
            nf[iao_pkg::FLG_N] = |(res & msb);
            nf[iao_pkg::FLG_Z] = (res == 32'h0);
            nf[iao_pkg::FLG_V] = 1'b0;
         end
         iao_pkg::OP_BIT_SET, iao_pkg::OP_BIT_CLR, iao_pkg::OP_BIT_INV: begin
            newByte[bitPos] = (opCode == iao_pkg::OP_BIT_SET) ? 1'b1
                   : (opCode == iao_pkg::OP_BIT_CLR) ? 1'b0
                   : ~bitSel;
            res   = {24'h000000, newByte};
            wrReg = !useMem;
            memWr = useMem;
         end
         iao_pkg::OP_BIT_TEST: begin
            res = {24'h000000, byteOp};
            nf[iao_pkg::FLG_Z] = ~bitSel;
         end
         iao_pkg::OP_C_AND:
            nf[iao_pkg::FLG_C] = flagsOut[iao_pkg::FLG_C] & bitSel;
         default:
            nf[iao_pkg::FLG_C] = flagsOut[iao_pkg::FLG_C] & ~bitSel;
      endcase
      taken = opValid && legal;
   end

   // register file: an operation's write wins over a same-cycle load
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         for (int i = 0; i < iao_pkg::NUM_REGS; i++)
            regs[i] <= iao_pkg::REG_RST;
      end else begin
         if (loadEn) regs[loadIdx] <= loadData;
         if (taken && wrReg) regs[dstSel[2:0]] <= wrOp(wsz, dstSel, dReg, res);
      end
   end

   // condition flags
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         flagsOut <= iao_pkg::FLAGS_RST;
      end else if (taken) begin
         flagsOut <= nf;
      end else if (flagLoadEn) begin
         flagsOut <= flagLoadData;
      end
   end

   // answer strobes and result capture
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         doneOut   <= 1'b0;
         errOut    <= 1'b0;
         memWrEn   <= 1'b0;
         memWrData <= 8'h00;
         resultOut <= iao_pkg::REG_RST;
         peekData  <= iao_pkg::REG_RST;
      end else begin
         doneOut  <= taken;
         errOut   <= opValid && !legal;  // refused ops change nothing
         memWrEn  <= taken && memWr;
         peekData <= regs[peekIdx];
         if (taken) begin
            resultOut <= res;
            memWrData <= newByte;
         end
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_took(iao_pkg::iao_op_t c);
      opValid && legal && opCode == c;
   endsequence
   chk_refused_op: assert property (opValid && !legal |=>
      errOut && !doneOut) else $error("refused op not flagged");
   chk_cmp_flags: assert property (s_took(iao_pkg::OP_COMPARE) |=>
      flagsOut[2] == ($past(dVal) == $past(sVal)) &&
      flagsOut[0] == ($past(dVal) < $past(sVal)))
      else $error("compare flags wrong");
   chk_negate_result: assert property (s_took(iao_pkg::OP_NEGATE) |=>
      resultOut == ((32'h0 - $past(dVal)) & $past(msk)))
      else $error("negate result wrong");
   chk_bit_test: assert property (s_took(iao_pkg::OP_BIT_TEST) |=>
      flagsOut[2] == !$past(bitSel) && !memWrEn)
      else $error("bit test zero flag wrong");
   chk_carry_and: assert property (s_took(iao_pkg::OP_C_AND) |=>
      flagsOut[0] == ($past(flagsOut[0]) && $past(bitSel)))
      else $error("carry and wrong");
   chk_shift_carry: assert property (s_took(iao_pkg::OP_SHL_R) |=>
      flagsOut[0] == $past(dVal[0]) && resultOut == ($past(dVal) >> 1))
      else $error("right shift carry wrong");
   chk_rotc_left: assert property (s_took(iao_pkg::OP_ROTC_L) |=>
      resultOut[0] == $past(flagsOut[0]) && flagsOut[0] == $past(top))
      else $error("rotate through carry wrong");
   chk_bit_set: assert property (s_took(iao_pkg::OP_BIT_SET) |=>
      resultOut[7:0] == ($past(byteOp) | (8'h01 << $past(bitPos))))
      else $error("bit set wrong");
   chk_mem_write: assert property (
      s_took(iao_pkg::OP_BIT_CLR) ##0 useMem |=> memWrEn &&
      memWrData == ($past(byteOp) & ~(8'h01 << $past(bitPos))))
      else $error("memory write strobe wrong");
   chk_divu_byte: assert property (s_took(iao_pkg::OP_DIV_U) ##0
      opSize == iao_pkg::SZ_B && sVal != 32'h0 |=>
      resultOut[7:0] == 8'($past(dvd) / $past(sVal)))
      else $error("unsigned divide quotient wrong");
endmodule : iao_alu
`default_nettype wire

// File: bench/tb.sv
// self-checking testbench for the integer alu datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic               sysClk = 1'b0;
   logic               rstB, opValid, useImm, bitFromReg, useMem;
   logic               loadEn, flagLoadEn, doneOut, errOut, memWrEn;
   iao_pkg::iao_op_t   opCode;
   iao_pkg::iao_size_t opSize;
   logic [3:0]         dstSel, srcSel, flagLoadData, flagsOut;
   logic [2:0]         bitImm, loadIdx, peekIdx;
   logic [31:0]        immData, loadData, resultOut, peekData;
   logic [7:0]         memRdData, memWrData;
   int                 failures = 0;
   int                 compares = 0;

   // free-running 100 MHz clock
   always #5 sysClk = ~sysClk;

   iao_alu u_iao_alu (.sys_clk(sysClk), .rst_b(rstB), .opValid(opValid),
      .opCode(opCode), .opSize(opSize), .dstSel(dstSel), .srcSel(srcSel),
      .useImm(useImm), .immData(immData), .bitImm(bitImm),
      .bitFromReg(bitFromReg), .useMem(useMem), .memRdData(memRdData),
      .loadEn(loadEn), .loadIdx(loadIdx), .loadData(loadData),
      .flagLoadEn(flagLoadEn), .flagLoadData(flagLoadData),
      .peekIdx(peekIdx), .resultOut(resultOut), .flagsOut(flagsOut),
      .doneOut(doneOut), .errOut(errOut), .memWrEn(memWrEn),
      .memWrData(memWrData), .peekData(peekData));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                      input string what);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
      end
   endtask : chk

   // whole-longword load through the test port, driven off the sampling edge
   task automatic load(input logic [2:0] idx, input logic [31:0] d);
      @(negedge sysClk);
      loadEn = 1'b1;
      loadIdx = idx;
      loadData = d;
      @(negedge sysClk);
      loadEn = 1'b0;
   endtask : load

   task automatic setf(input logic [3:0] f);
      @(negedge sysClk);
      flagLoadEn = 1'b1;
      flagLoadData = f;
      @(negedge sysClk);
      flagLoadEn = 1'b0;
   endtask : setf

   // one request; the answer pulse stands only in the following cycle
   task automatic op(input iao_pkg::iao_op_t c, input iao_pkg::iao_size_t s,
                     input logic [3:0] d, input logic e);
      @(negedge sysClk);
      opValid = 1'b1;
      opCode = c;
      opSize = s;
      dstSel = d;
      @(negedge sysClk);
      opValid = 1'b0;
      chk({doneOut, errOut}, e ? 2'b01 : 2'b10, "answer");
   endtask : op

   task automatic peek(input logic [2:0] idx, input logic [31:0] exp);
      peekIdx = idx;
      @(negedge sysClk);
      chk(peekData, exp, "register");
   endtask : peek

   task automatic t_divide;
      load(3'h0, 32'h0000_0064);
      load(3'h1, 32'h0000_0007);
      srcSel = 4'h9;
      op(iao_pkg::OP_DIV_U, iao_pkg::SZ_B, 4'h0, 1'b0);
      chk(resultOut, 32'h0000_020e, "divu byte");
      peek(3'h0, 32'h0000_020e);
      load(3'h0, 32'h0000_ff9c);
      op(iao_pkg::OP_DIV_S, iao_pkg::SZ_B, 4'h0, 1'b0);
      peek(3'h0, 32'h0000_fef2);
      load(3'h0, 32'hffff_ff9c);
      srcSel = 4'h1;
      op(iao_pkg::OP_DIV_S, iao_pkg::SZ_W, 4'h0, 1'b0);
      chk(flagsOut[3], 1'b1, "divs n");
      peek(3'h0, 32'hfffe_fff2);
      load(3'h0, 32'h000f_4240);
      load(3'h1, 32'h0000_0100);
      op(iao_pkg::OP_DIV_U, iao_pkg::SZ_W, 4'h0, 1'b0);
      peek(3'h0, 32'h0040_0f42);
      load(3'h1, 32'h0000_0000);
      op(iao_pkg::OP_DIV_U, iao_pkg::SZ_W, 4'h0, 1'b0);
      chk(flagsOut[2], 1'b1, "div zero");
      op(iao_pkg::OP_DIV_U, iao_pkg::SZ_L, 4'h0, 1'b1);
      peek(3'h0, 32'h0040_0f42);
   endtask : t_divide

   task automatic t_cmp_neg_ext;
      load(3'h2, 32'h0000_0005);
      immData = 32'h0000_0006;
      useImm = 1'b1;
      op(iao_pkg::OP_COMPARE, iao_pkg::SZ_B, 4'ha, 1'b0);
      chk(flagsOut, 4'h9, "cmp borrow");
      peek(3'h2, 32'h0000_0005);
      useImm = 1'b0;
      load(3'h3, 32'h0000_0005);
      srcSel = 4'h3;
      op(iao_pkg::OP_COMPARE, iao_pkg::SZ_W, 4'h2, 1'b0);
      chk(flagsOut, 4'h4, "cmp equal");
      load(3'h3, 32'h0000_0001);
      op(iao_pkg::OP_NEGATE, iao_pkg::SZ_W, 4'h3, 1'b0);
      chk(flagsOut[0], 1'b1, "neg carry");
      peek(3'h3, 32'h0000_ffff);
      load(3'h4, 32'h1234_5680);
      op(iao_pkg::OP_EXT_SIGN, iao_pkg::SZ_W, 4'h4, 1'b0);
      peek(3'h4, 32'h1234_ff80);
      op(iao_pkg::OP_EXT_SIGN, iao_pkg::SZ_L, 4'h4, 1'b0);
      peek(3'h4, 32'hffff_ff80);
      op(iao_pkg::OP_EXT_ZERO, iao_pkg::SZ_W, 4'h4, 1'b0);
      peek(3'h4, 32'hffff_0080);
      op(iao_pkg::OP_EXT_ZERO, iao_pkg::SZ_L, 4'h4, 1'b0);
      peek(3'h4, 32'h0000_0080);
      op(iao_pkg::OP_EXT_SIGN, iao_pkg::SZ_B, 4'h4, 1'b1);
   endtask : t_cmp_neg_ext

   task automatic t_logic;
      load(3'h5, 32'hf0f0_1234);
      useImm = 1'b1;
      immData = 32'hff00_ff00;
      op(iao_pkg::OP_LOG_AND, iao_pkg::SZ_L, 4'h5, 1'b0);
      peek(3'h5, 32'hf000_1200);
      immData = 32'h0000_000f;
      op(iao_pkg::OP_LOG_OR, iao_pkg::SZ_L, 4'h5, 1'b0);
      peek(3'h5, 32'hf000_120f);
      immData = 32'hffff_ffff;
      op(iao_pkg::OP_LOG_XOR, iao_pkg::SZ_L, 4'h5, 1'b0);
      peek(3'h5, 32'h0fff_edf0);
      op(iao_pkg::OP_LOG_INV, iao_pkg::SZ_L, 4'h5, 1'b0);
      chk(flagsOut[3:1], 3'b100, "inv flags");
      useImm = 1'b0;
      load(3'h6, 32'h0000_0081);
      srcSel = 4'he;
      op(iao_pkg::OP_LOG_OR, iao_pkg::SZ_B, 4'hd, 1'b0);
      peek(3'h5, 32'hf000_128f);
      op(iao_pkg::OP_LOG_INV, iao_pkg::SZ_W, 4'h5, 1'b0);
      peek(3'h5, 32'hf000_ed70);
      op(iao_pkg::OP_LOG_INV, iao_pkg::SZ_W, 4'hd, 1'b0);
      peek(3'h5, 32'h0fff_ed70);
   endtask : t_logic

   // each of the eight byte shifts starts from 0x41 with carry preset to one
   task automatic t_shift;
      iao_pkg::iao_op_t ops [8] = '{iao_pkg::OP_SHA_L, iao_pkg::OP_SHA_R,
         iao_pkg::OP_SHL_L, iao_pkg::OP_SHL_R, iao_pkg::OP_ROT_L,
         iao_pkg::OP_ROT_R, iao_pkg::OP_ROTC_L, iao_pkg::OP_ROTC_R};
      logic [7:0] ex [8] = '{8'h82, 8'h20, 8'h82, 8'h20, 8'h82, 8'ha0,
                             8'h83, 8'ha0};
      logic       cy [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
      for (int i = 0; i < 8; i++) begin
         load(3'h7, 32'h0000_0041);
         setf(4'h1);
         op(ops[i], iao_pkg::SZ_B, 4'hf, 1'b0);
         peek(3'h7, {24'h0, ex[i]});
         chk(flagsOut, {ex[i][7], ex[i] == 8'h00, 1'b0, cy[i]}, "shf");
      end
      load(3'h7, 32'h8000_0001);
      op(iao_pkg::OP_SHA_R, iao_pkg::SZ_L, 4'h7, 1'b0);
      chk(flagsOut, 4'h9, "sar flags");
      peek(3'h7, 32'hc000_0000);
   endtask : t_shift

   task automatic t_bits;
      load(3'h1, 32'h0000_000b);
      load(3'h6, 32'h0000_005a);
      setf(4'ha);
      srcSel = 4'h9;
      bitImm = 3'h0;
      op(iao_pkg::OP_BIT_SET, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut, 4'ha, "set flags");
      peek(3'h6, 32'h0000_005b);
      bitFromReg = 1'b1;
      op(iao_pkg::OP_BIT_CLR, iao_pkg::SZ_B, 4'he, 1'b0);
      peek(3'h6, 32'h0000_0053);
      bitFromReg = 1'b0;
      bitImm = 3'h7;
      op(iao_pkg::OP_BIT_INV, iao_pkg::SZ_B, 4'he, 1'b0);
      peek(3'h6, 32'h0000_00d3);
      bitImm = 3'h1;
      op(iao_pkg::OP_BIT_TEST, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut[2], 1'b0, "test one");
      bitFromReg = 1'b1;
      op(iao_pkg::OP_BIT_TEST, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut[2], 1'b1, "test zero");
      peek(3'h6, 32'h0000_00d3);
      op(iao_pkg::OP_C_ANDN, iao_pkg::SZ_B, 4'he, 1'b1);
      bitFromReg = 1'b0;
      setf(4'h1);
      op(iao_pkg::OP_C_AND, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut[0], 1'b1, "cand one");
      bitImm = 3'h2;
      op(iao_pkg::OP_C_AND, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut[0], 1'b0, "cand zero");
      setf(4'h1);
      op(iao_pkg::OP_C_ANDN, iao_pkg::SZ_B, 4'he, 1'b0);
      chk(flagsOut[0], 1'b1, "candn");
      op(iao_pkg::OP_BIT_SET, iao_pkg::SZ_W, 4'he, 1'b1);
      useMem = 1'b1;
      memRdData = 8'h81;
      bitImm = 3'h4;
      op(iao_pkg::OP_BIT_SET, iao_pkg::SZ_B, 4'he, 1'b0);
      chk({memWrEn, memWrData}, 9'h191, "mem set");
      bitImm = 3'h7;
      op(iao_pkg::OP_BIT_CLR, iao_pkg::SZ_B, 4'he, 1'b0);
      chk({memWrEn, memWrData}, 9'h101, "mem clear");
      useMem = 1'b0;
      peek(3'h6, 32'h0000_00d3);
   endtask : t_bits

   task automatic end_of_test;
      $display("failures=%0d compares=%0d", failures, compares);
      if (failures == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge sysClk);
      failures++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      end_of_test();
   end

   // main sequence: idle inputs, ten reset cycles, then the scenarios
   initial begin
      {rstB, opValid, useImm, bitFromReg, useMem, loadEn, flagLoadEn} = '0;
      opCode = iao_pkg::OP_DIV_U;
      opSize = iao_pkg::SZ_B;
      {dstSel, srcSel, flagLoadData, bitImm, loadIdx, peekIdx} = '0;
      {immData, loadData, memRdData} = '0;
      repeat (10) @(negedge sysClk);
      rstB = 1'b1;
      chk(resultOut, 32'h0000_0000, "reset result");
      chk({flagsOut, doneOut, errOut}, 6'h00, "reset flags");
      t_divide();
      t_cmp_neg_ext();
      t_logic();
      t_shift();
      t_bits();
      end_of_test();
   end
endmodule : tb
`default_nettype wire
